// file: host_bus_and_csr_control.sv
// Host bus master, register slave and halt control of the network controller
`timescale 1ns/10ps
`default_nettype none
module host_bus_and_csr_control #(
	parameter int INIT_CYCLES = host_bus_pkg::INIT_CYCLES_DEFAULT,
	parameter int DATA_W = 16
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ready_ack_out,
	output logic ready_ack_oe,
	input wire logic bus_grant,
	output logic bus_hold_req,
	output logic latch_strobe_out,
	output logic latch_strobe_oe,
	output logic [DATA_W-1:0] muxed_address_data_lines_out,
	output logic muxed_address_data_lines_oe,
	input wire logic master_go,
	input wire logic [DATA_W-1:0] master_addr,
	input wire logic [DATA_W-1:0] master_wdata,
	input wire host_bus_pkg::net_events_t net_events,
	output logic irq
);
	// ************************************************************
	// Reset and pin synchronisers
	// ************************************************************
	logic rst_meta_ff, rst_n;
	logic grant_meta_ff, grant_ff;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			grant_meta_ff <= 1'b0;
			grant_ff <= 1'b0;
		end else begin
			grant_meta_ff <= bus_grant;
			grant_ff <= grant_meta_ff;
		end
	end
	// ************************************************************
	// Register bus decode
	// ************************************************************
	logic [15:0] status_ff, nxt_status, status_view;
	logic [15:0] aux_a_ff;
	logic [7:0] aux_b_ff;
	host_bus_pkg::bus_cfg_t cfg_ff;
	logic [5:0] irq_status_ff, irq_mask_ff, irq_set;
	logic [11:0] buffer_byte_count_ff, rx_len;
	logic [31:0] rd_mux, prdata_ff;
	logic slverr_ff, mapped, apb_setup, apb_wr;
	logic halt_pending_ff, halt_req, init_done, master_done;
	logic [7:0] init_cnt_ff;
	logic [15:0] w;
	assign pready = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;
	assign w = pwdata[15:0];
	assign prdata = prdata_ff;
	assign pslverr = slverr_ff & psel & penable;
	// Open drain: only ever pull low, the pull-up supplies idle
	assign ready_ack_out = 1'b0;
	assign ready_ack_oe = psel & penable;
	always_comb begin
		case (paddr)
			host_bus_pkg::ADDR_STATUS, host_bus_pkg::ADDR_AUX_A,
			host_bus_pkg::ADDR_AUX_B, host_bus_pkg::ADDR_BUS_CFG,
			host_bus_pkg::ADDR_IRQ_STATUS, host_bus_pkg::ADDR_IRQ_MASK,
			host_bus_pkg::ADDR_RX_COUNT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	always_comb begin
		status_view = status_ff;
		status_view[host_bus_pkg::ST_INTERRUPT_PENDING_FLAG] = status_ff[host_bus_pkg::ST_IE]
			& (|(status_ff & host_bus_pkg::STATUS_W1C_MASK));
	end
	// Two's complement count gives the buffer length
	assign rx_len = 12'(~buffer_byte_count_ff + 12'h001);
	always_comb begin
		rd_mux = 32'h00000000;
		case (paddr)
			host_bus_pkg::ADDR_STATUS: rd_mux[15:0] = status_view;
			host_bus_pkg::ADDR_AUX_A: rd_mux[15:0] = aux_a_ff;
			host_bus_pkg::ADDR_AUX_B: rd_mux[7:0] = aux_b_ff;
			host_bus_pkg::ADDR_BUS_CFG: rd_mux[2:0] = cfg_ff;
			host_bus_pkg::ADDR_IRQ_STATUS: rd_mux[5:0] = irq_status_ff;
			host_bus_pkg::ADDR_IRQ_MASK: rd_mux[5:0] = irq_mask_ff;
			host_bus_pkg::ADDR_RX_COUNT: begin
				rd_mux[11:0] = buffer_byte_count_ff;
				rd_mux[host_bus_pkg::RX_LEN_LSB +: 12] = rx_len;
				rd_mux[host_bus_pkg::RX_ZERO_BIT] = (buffer_byte_count_ff == 12'h000);
			end
			default: rd_mux = 32'h00000000;
		endcase
	end
	// Read data frozen at setup, so status events cannot disturb it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else if (apb_setup) begin
			prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
			slverr_ff <= ~mapped;
		end
	end
	// ************************************************************
	// Halt latch and main status register
	// ************************************************************
	assign halt_req = apb_wr & (paddr == host_bus_pkg::ADDR_STATUS)
		& w[host_bus_pkg::ST_HALT] & ~status_ff[host_bus_pkg::ST_HALT];
	// Applied one cycle later, after the access has completed
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_pending_ff <= 1'b0;
		end else begin
			halt_pending_ff <= halt_req;
		end
	end
	always_comb begin
		nxt_status = status_ff;
		if (halt_pending_ff) begin
			nxt_status = 16'h0000;
			nxt_status[host_bus_pkg::ST_HALT] = 1'b1;
		end else begin
			if (apb_wr && paddr == host_bus_pkg::ADDR_STATUS) begin
				nxt_status[host_bus_pkg::ST_IE] = w[host_bus_pkg::ST_IE];
				nxt_status = nxt_status & ~(w & host_bus_pkg::STATUS_W1C_MASK);
				if ((w[host_bus_pkg::ST_INIT] | w[host_bus_pkg::ST_START])
					& ~w[host_bus_pkg::ST_HALT]) begin
					nxt_status[host_bus_pkg::ST_HALT] = 1'b0;
					nxt_status[host_bus_pkg::ST_INIT] = status_ff[host_bus_pkg::ST_INIT]
						| w[host_bus_pkg::ST_INIT];
					nxt_status[host_bus_pkg::ST_START] = status_ff[host_bus_pkg::ST_START]
						| w[host_bus_pkg::ST_START];
				end
			end
			// Events after clears so a set wins
			if (irq_set[host_bus_pkg::IRQ_INIT_COMPLETE_FLAG]) begin
				nxt_status[host_bus_pkg::ST_INIT_COMPLETE_FLAG] = 1'b1;
			end
			if (irq_set[host_bus_pkg::IRQ_OVERLEN]) begin
				nxt_status[host_bus_pkg::ST_OVERLEN] = 1'b1;
			end
			if (irq_set[host_bus_pkg::IRQ_HBFAIL]) begin
				nxt_status[host_bus_pkg::ST_HBFAIL] = 1'b1;
			end
			if (irq_set[host_bus_pkg::IRQ_LOOP]) begin
				nxt_status[host_bus_pkg::ST_LOOP_PASS] = 1'b1;
			end
		end
		nxt_status[host_bus_pkg::ST_INTERRUPT_PENDING_FLAG] = 1'b0;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= host_bus_pkg::STATUS_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end
	// ************************************************************
	// Configuration registers
	// ************************************************************
	// Auxiliary registers: no initialization path writes them
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_a_ff <= host_bus_pkg::AUX_A_RESET;
			aux_b_ff <= host_bus_pkg::AUX_B_RESET;
		end else if (apb_wr) begin
			if (paddr == host_bus_pkg::ADDR_AUX_A) begin
				aux_a_ff <= w;
			end
			if (paddr == host_bus_pkg::ADDR_AUX_B) begin
				aux_b_ff <= w[7:0];
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= host_bus_pkg::BUS_CFG_RESET;
		end else if (halt_pending_ff) begin
			cfg_ff <= host_bus_pkg::BUS_CFG_RESET;
		end else if (apb_wr && paddr == host_bus_pkg::ADDR_BUS_CFG) begin
			cfg_ff <= pwdata[2:0];
		end
	end
	// Zero count is undefined for software; flagged, never used as 4096
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			buffer_byte_count_ff <= host_bus_pkg::BUFFER_BYTE_COUNT_RESET;
		end else if (apb_wr && paddr == host_bus_pkg::ADDR_RX_COUNT) begin
			buffer_byte_count_ff <= pwdata[11:0];
		end
	end
	// ************************************************************
	// Initialization sequence
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_ff <= 8'h00;
		end else if (halt_pending_ff) begin
			init_cnt_ff <= 8'h00;
		end else if (apb_wr && paddr == host_bus_pkg::ADDR_STATUS
			&& w[host_bus_pkg::ST_INIT] && !w[host_bus_pkg::ST_HALT]) begin
			init_cnt_ff <= 8'(INIT_CYCLES);
		end else if (init_cnt_ff != 8'h00) begin
			init_cnt_ff <= init_cnt_ff - 8'h01;
		end
	end
	assign init_done = (init_cnt_ff == 8'h01);
	// ************************************************************
	// Events and interrupt
	// ************************************************************
	always_comb begin
		irq_set = 6'h00;
		irq_set[host_bus_pkg::IRQ_INIT_COMPLETE_FLAG] = init_done;
		irq_set[host_bus_pkg::IRQ_OVERLEN] = net_events.overlength
			& ~status_ff[host_bus_pkg::ST_HALT];
		irq_set[host_bus_pkg::IRQ_HBFAIL] = net_events.heartbeat_fail
			& ~status_ff[host_bus_pkg::ST_HALT];
		// Foreign frames on a live medium are ignored, not failures
		irq_set[host_bus_pkg::IRQ_LOOP] = net_events.lb_valid & net_events.lb_own
			& net_events.lb_match & ~status_ff[host_bus_pkg::ST_HALT];
		irq_set[host_bus_pkg::IRQ_MASTER] = master_done;
		irq_set[host_bus_pkg::IRQ_ZERO_CNT] = apb_wr
			& (paddr == host_bus_pkg::ADDR_RX_COUNT) & (pwdata[11:0] == 12'h000);
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_ff <= host_bus_pkg::IRQ_RESET;
			irq_mask_ff <= host_bus_pkg::IRQ_RESET;
			irq <= 1'b0;
		end else begin
			if (apb_wr && paddr == host_bus_pkg::ADDR_IRQ_STATUS) begin
				irq_status_ff <= (irq_status_ff & ~pwdata[5:0]) | irq_set;
			end else begin
				irq_status_ff <= irq_status_ff | irq_set;
			end
			if (apb_wr && paddr == host_bus_pkg::ADDR_IRQ_MASK) begin
				irq_mask_ff <= pwdata[5:0];
			end
			irq <= |(irq_status_ff & irq_mask_ff);
		end
	end
	// ************************************************************
	// Bus master sequencer
	// ************************************************************
	host_bus_pkg::master_state_t state_ff, nxt_state;
	logic strobe_active, strobe_ff, strobe_oe_ff, mad_oe_ff, hold_ff;
	logic [DATA_W-1:0] mad_ff, wdata_ordered;
	assign strobe_active = ~cfg_ff.strobe_polarity_select;
	assign wdata_ordered = cfg_ff.byte_swap_bit
		? {master_wdata[7:0], master_wdata[DATA_W-1:8]} : master_wdata;
	assign master_done = (state_ff == host_bus_pkg::M_END);
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			host_bus_pkg::M_IDLE: begin
				if (master_go && status_ff[host_bus_pkg::ST_START]
					&& !status_ff[host_bus_pkg::ST_HALT]) begin
					nxt_state = host_bus_pkg::M_REQ;
				end
			end
			host_bus_pkg::M_REQ: begin
				if (grant_ff) begin
					nxt_state = host_bus_pkg::M_ADDR;
				end
			end
			host_bus_pkg::M_ADDR: nxt_state = host_bus_pkg::M_DATA;
			host_bus_pkg::M_DATA: nxt_state = host_bus_pkg::M_END;
			host_bus_pkg::M_END: nxt_state = host_bus_pkg::M_WAIT;
			// Hold off until the current grant is withdrawn
			host_bus_pkg::M_WAIT: begin
				if (!grant_ff) begin
					nxt_state = host_bus_pkg::M_IDLE;
				end
			end
			default: nxt_state = host_bus_pkg::M_IDLE;
		endcase
		if (halt_pending_ff) begin
			nxt_state = host_bus_pkg::M_IDLE;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= host_bus_pkg::M_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end
	// Pin levels follow the next state so they change with it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_ff <= 1'b1;
			strobe_oe_ff <= 1'b0;
			mad_oe_ff <= 1'b0;
			hold_ff <= 1'b0;
			mad_ff <= '0;
		end else begin
			hold_ff <= (nxt_state != host_bus_pkg::M_IDLE)
				&& (nxt_state != host_bus_pkg::M_WAIT);
			mad_oe_ff <= (nxt_state == host_bus_pkg::M_ADDR)
				|| (nxt_state == host_bus_pkg::M_DATA);
			strobe_oe_ff <= (nxt_state == host_bus_pkg::M_ADDR)
				|| (nxt_state == host_bus_pkg::M_DATA)
				|| (nxt_state == host_bus_pkg::M_END);
			if (nxt_state == host_bus_pkg::M_ADDR) begin
				strobe_ff <= strobe_active;
				mad_ff <= master_addr;
			end else if (nxt_state == host_bus_pkg::M_END) begin
				// High before float: active-high drives high, active-low stays idle
				strobe_ff <= 1'b1;
			end else if (nxt_state == host_bus_pkg::M_DATA) begin
				strobe_ff <= ~strobe_active;
				mad_ff <= wdata_ordered;
			end else begin
				strobe_ff <= 1'b1;
			end
		end
	end
	assign bus_hold_req = hold_ff;
	assign latch_strobe_out = strobe_ff;
	assign latch_strobe_oe = strobe_oe_ff;
	assign muxed_address_data_lines_out = mad_ff;
	assign muxed_address_data_lines_oe = mad_oe_ff;
endmodule : host_bus_and_csr_control
`default_nettype wire

// file: host_bus_pkg.sv
// Shared constants, register map and types of the host bus and control block
`default_nettype none
package host_bus_pkg;
	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_AUX_A = 8'h04;
	localparam logic [7:0] ADDR_AUX_B = 8'h08;
	localparam logic [7:0] ADDR_BUS_CFG = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_RX_COUNT = 8'h18;
	// ************************************************************
	// Main status and control bit positions
	// ************************************************************
	localparam int ST_INIT = 0;
	localparam int ST_START = 1;
	localparam int ST_HALT = 2;
	localparam int ST_LOOP_PASS = 3;
	localparam int ST_IE = 6;
	localparam int ST_INTERRUPT_PENDING_FLAG = 7;
	localparam int ST_INIT_COMPLETE_FLAG = 8;
	localparam int ST_OVERLEN = 12;
	localparam int ST_HBFAIL = 13;
	localparam int STATUS_W = 16;
	localparam logic [15:0] STATUS_RESET = 16'h0004;
	localparam logic [15:0] STATUS_W1C_MASK = 16'h3108;
	localparam logic [15:0] AUX_A_RESET = 16'h0000;
	localparam logic [7:0] AUX_B_RESET = 8'h00;
	// ************************************************************
	// Interrupt status and mask bit positions
	// ************************************************************
	localparam int IRQ_INIT_COMPLETE_FLAG = 0;
	localparam int IRQ_OVERLEN = 1;
	localparam int IRQ_HBFAIL = 2;
	localparam int IRQ_LOOP = 3;
	localparam int IRQ_MASTER = 4;
	localparam int IRQ_ZERO_CNT = 5;
	localparam int IRQ_W = 6;
	localparam logic [5:0] IRQ_RESET = 6'h00;
	// ************************************************************
	// Receive byte count layout and timing
	// ************************************************************
	localparam int BUFFER_BYTE_COUNT_W = 12;
	localparam int RX_LEN_LSB = 16;
	localparam int RX_ZERO_BIT = 31;
	localparam int INIT_CYCLES_DEFAULT = 4;
	localparam logic [11:0] BUFFER_BYTE_COUNT_RESET = 12'h000;
	typedef struct packed {
		logic byte_swap_bit;
		logic strobe_polarity_select;
		logic byte_control_select;
	} bus_cfg_t;
	localparam bus_cfg_t BUS_CFG_RESET = 3'h0;
	typedef struct packed {
		logic overlength;
		logic heartbeat_fail;
		logic lb_valid;
		logic lb_own;
		logic lb_match;
	} net_events_t;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_REQ = 3'b001,
		M_ADDR = 3'b010,
		M_DATA = 3'b011,
		M_END = 3'b100,
		M_WAIT = 3'b101
	} master_state_t;
endpackage : host_bus_pkg
`default_nettype wire

// file: host_bus_and_csr_control_properties.sv
// Port checks of the host bus and control block
`timescale 1ns/10ps
`default_nettype none
module host_bus_and_csr_control_properties (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ready_ack_out,
	input wire logic ready_ack_oe,
	input wire logic bus_hold_req,
	input wire logic latch_strobe_out,
	input wire logic latch_strobe_oe,
	input wire logic muxed_address_data_lines_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ********************
	// Master tenure
	// ********************
	property p_strobe_high_release;
		$fell(latch_strobe_oe) |-> $past(latch_strobe_out) && !muxed_address_data_lines_oe;
	endproperty
	a_strobe_high_release: assert property (p_strobe_high_release)
		else $error("strobe not high before float");
	property p_end_strobe;
		$fell(muxed_address_data_lines_oe) |-> latch_strobe_out && latch_strobe_oe;
	endproperty
	a_end_strobe: assert property (p_end_strobe)
		else $error("strobe not driven high at end");
	property p_float_after_hold;
		$fell(bus_hold_req) |-> ##[0:1] !latch_strobe_oe;
	endproperty
	a_float_after_hold: assert property (p_float_after_hold)
		else $error("strobe still driven after release");
	property p_no_master_idle;
		!bus_hold_req |=> !muxed_address_data_lines_oe;
	endproperty
	a_no_master_idle: assert property (p_no_master_idle)
		else $error("lines driven without request");
	property p_lines_in_tenure;
		muxed_address_data_lines_oe |-> latch_strobe_oe && bus_hold_req;
	endproperty
	a_lines_in_tenure: assert property (p_lines_in_tenure)
		else $error("lines driven outside tenure");
	// ********************
	// Slave port
	// ********************
	property p_access_done;
		psel && penable |-> pready;
	endproperty
	a_access_done: assert property (p_access_done)
		else $error("access not completed");
	property p_open_drain;
		ready_ack_oe |-> !ready_ack_out;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("ready driven high");
	property p_ack_in_access;
		ready_ack_oe == (psel && penable);
	endproperty
	a_ack_in_access: assert property (p_ack_in_access)
		else $error("ready drive outside access");
	property p_read_stable;
		psel && penable && !pwrite |=> $stable(prdata);
	endproperty
	a_read_stable: assert property (p_read_stable)
		else $error("read data moved");
	c_tenure: cover property ($fell(latch_strobe_oe));
	c_read: cover property (psel && penable && !pwrite);
	c_err: cover property (pslverr);
endmodule : host_bus_and_csr_control_properties
bind host_bus_and_csr_control host_bus_and_csr_control_properties u_props (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.ready_ack_out(ready_ack_out),
	.ready_ack_oe(ready_ack_oe),
	.bus_hold_req(bus_hold_req),
	.latch_strobe_out(latch_strobe_out),
	.latch_strobe_oe(latch_strobe_oe),
	.muxed_address_data_lines_oe(muxed_address_data_lines_oe)
);
`default_nettype wire

// file: host_bus_partner.sv
// Host bus arbiter and external address latch model
`timescale 1ns/10ps
`default_nettype none
module host_bus_partner #(
	parameter int GRANT_DLY = 3
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic strobe_pol,
	input wire logic bus_hold_req,
	input wire logic latch_strobe_out,
	input wire logic latch_strobe_oe,
	input wire logic [15:0] mad_out,
	input wire logic mad_oe,
	output logic bus_grant,
	output logic [15:0] latch_q,
	output logic [15:0] data_q,
	output int n_tenure
);
	int cnt;
	logic addr_seen;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_grant <= 1'b0;
			cnt <= 0;
			addr_seen <= 1'b0;
			latch_q <= 16'h0000;
			data_q <= 16'h0000;
			n_tenure <= 0;
		end else begin
			// Grant after a delay, withdrawn with the request
			if (!bus_hold_req) begin
				bus_grant <= 1'b0;
				cnt <= 0;
			end else if (cnt == GRANT_DLY) begin
				bus_grant <= 1'b1;
			end else begin
				cnt <= cnt + 1;
			end
			// Latch only while lines are driven and strobe is active
			if (latch_strobe_oe && mad_oe && latch_strobe_out != strobe_pol) begin
				latch_q <= mad_out;
				addr_seen <= 1'b1;
			end else if (addr_seen && mad_oe) begin
				data_q <= mad_out;
				addr_seen <= 1'b0;
				n_tenure <= n_tenure + 1;
			end
		end
	end
endmodule : host_bus_partner
`default_nettype wire

// file: test_host_bus_and_csr_control.sv
// Self-checking bench of the host bus and control block
`timescale 1ns/10ps
`default_nettype none
module test_host_bus_and_csr_control;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} row_t;
	logic sys_clk = 1'b0;
	logic reset_n, psel, penable, pwrite, pready, pslverr, ra_out, ra_oe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic ev, bus_grant, bus_hold_req, strobe_out, strobe_oe, mad_oe, master_go, irq, strobe_pol;
	logic [15:0] mad_out, master_addr, master_wdata, latch_q, data_q;
	host_bus_pkg::net_events_t net_events;
	int n_tenure, n0, k, n_fail, total_checks;
	row_t rows[8] = '{
		'{host_bus_pkg::ADDR_AUX_A, 32'h0000_1234, 32'h0000_1234, 1'b0},
		'{host_bus_pkg::ADDR_AUX_B, 32'h0000_01A5, 32'h0000_00A5, 1'b0},
		'{host_bus_pkg::ADDR_BUS_CFG, 32'h0000_0007, 32'h0000_0007, 1'b0},
		'{host_bus_pkg::ADDR_IRQ_MASK, 32'h0000_003F, 32'h0000_003F, 1'b0},
		'{host_bus_pkg::ADDR_RX_COUNT, 32'h0000_0010, 32'h0FF0_0010, 1'b0},
		'{host_bus_pkg::ADDR_RX_COUNT, 32'h0000_0FFF, 32'h0001_0FFF, 1'b0},
		'{host_bus_pkg::ADDR_RX_COUNT, 32'h0000_0000, 32'h8000_0000, 1'b0},
		'{8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}
	};
	always #4 sys_clk = ~sys_clk;
	host_bus_and_csr_control #(.INIT_CYCLES(2)) u_host_bus_and_csr_control (
		.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ready_ack_out(ra_out), .ready_ack_oe(ra_oe),
		.bus_grant(bus_grant), .bus_hold_req(bus_hold_req), .latch_strobe_out(strobe_out),
		.latch_strobe_oe(strobe_oe), .muxed_address_data_lines_out(mad_out),
		.muxed_address_data_lines_oe(mad_oe), .master_go(master_go),
		.master_addr(master_addr), .master_wdata(master_wdata),
		.net_events(net_events), .irq(irq)
	);
	host_bus_partner u_host_bus_partner (
		.sys_clk(sys_clk), .reset_n(reset_n), .strobe_pol(strobe_pol),
		.bus_hold_req(bus_hold_req), .latch_strobe_out(strobe_out),
		.latch_strobe_oe(strobe_oe), .mad_out(mad_out), .mad_oe(mad_oe),
		.bus_grant(bus_grant), .latch_q(latch_q), .data_q(data_q), .n_tenure(n_tenure)
	);
	// ********************
	// Shared tasks
	// ********************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge sys_clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %s exp=%h got=%h", n, x, g);
		end
	endtask : chk
	task automatic pulse(input logic [4:0] v);
		net_events <= host_bus_pkg::net_events_t'(v);
		@(posedge sys_clk);
		net_events <= '0;
		apb(0, host_bus_pkg::ADDR_STATUS, 32'h0);
	endtask : pulse
	task automatic conclude();
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		conclude();
	end
	initial begin
		{reset_n, psel, penable, pwrite, master_go, strobe_pol} = '0;
		{paddr, pwdata, master_addr, master_wdata} = '0;
		net_events = '0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			apb(0, 8'(i * 4), 32'h0);
			chk("reset_val", (i == 0) ? 32'h0000_0004 : 32'h0, rv);
		end
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 32'h0);
			chk("row_data", rows[i].x, rv);
			chk("row_err", {31'h0, rows[i].e}, {31'h0, ev});
		end
		apb(0, host_bus_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("zero_cnt_flag", 32'h0000_0020, rv & 32'h0000_0020);
		// ********************
		// Init, preserved aux registers, interrupt
		// ********************
		apb(1, host_bus_pkg::ADDR_IRQ_STATUS, 32'h0000_003F);
		apb(1, host_bus_pkg::ADDR_STATUS, 32'h0000_0041);
		repeat (8) @(posedge sys_clk);
		apb(0, host_bus_pkg::ADDR_STATUS, 32'h0);
		chk("init_done", 32'h0000_0180, rv & 32'h0000_0184);
		apb(0, host_bus_pkg::ADDR_AUX_A, 32'h0);
		chk("aux_a", 32'h0000_1234, rv);
		apb(0, host_bus_pkg::ADDR_AUX_B, 32'h0);
		chk("aux_b", 32'h0000_00A5, rv);
		chk("irq_on", 32'h1, {31'h0, irq});
		apb(1, host_bus_pkg::ADDR_IRQ_MASK, 32'h0);
		// Mask lands at the access edge, irq register follows one edge later
		repeat (2) @(posedge sys_clk);
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1, host_bus_pkg::ADDR_IRQ_STATUS, 32'h0000_003F);
		apb(0, host_bus_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("irq_clear", 32'h0, rv);
		apb(1, host_bus_pkg::ADDR_IRQ_MASK, 32'h0000_003F);
		// ********************
		// Master tenure, both strobe polarities
		// ********************
		for (int p = 0; p < 2; p++) begin
			strobe_pol <= p[0];
			// Second pass also swaps bytes of the data word
			apb(1, host_bus_pkg::ADDR_BUS_CFG, {29'h0, p[0], p[0], 1'b0});
			apb(1, host_bus_pkg::ADDR_STATUS, 32'h0000_0042);
			master_addr <= 16'(16'h1A50 + p);
			master_wdata <= 16'(16'hC3E0 + p);
			n0 = n_tenure;
			master_go <= 1'b1;
			@(posedge sys_clk);
			master_go <= 1'b0;
			k = 0;
			while (n_tenure == n0 && k < 100) begin
				@(posedge sys_clk);
				k++;
			end
			chk("latch_addr", 32'(16'h1A50 + p), {16'h0, latch_q});
			chk("latch_data", (p == 0) ? 32'h0000_C3E0 : 32'h0000_E1C3, {16'h0, data_q});
			repeat (20) @(posedge sys_clk);
			chk("no_extra", 32'(n0 + 1), 32'(n_tenure));
		end
		apb(0, host_bus_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("master_irq", 32'h0000_0010, rv & 32'h0000_0010);
		// ********************
		// Network events, loopback filtering
		// ********************
		pulse(5'b00101);
		chk("foreign_lb", 32'h0, rv & 32'h0000_0008);
		pulse(5'b00111);
		chk("own_lb", 32'h0000_0008, rv & 32'h0000_0008);
		pulse(5'b10000);
		pulse(5'b01000);
		chk("events", 32'h0000_3088, rv & 32'h0000_3088);
		// ********************
		// Halt handling
		// ********************
		apb(1, host_bus_pkg::ADDR_STATUS, 32'h0000_0004);
		chk("halt_err", 32'h0, {31'h0, ev});
		apb(0, host_bus_pkg::ADDR_STATUS, 32'h0);
		chk("halt_status", 32'h0000_0004, rv);
		apb(0, host_bus_pkg::ADDR_BUS_CFG, 32'h0);
		chk("halt_cfg", 32'h0, rv);
		apb(0, host_bus_pkg::ADDR_AUX_A, 32'h0);
		chk("halt_aux_a", 32'h0000_1234, rv);
		pulse(5'b10000);
		chk("halted_event", 32'h0000_0004, rv);
		apb(1, host_bus_pkg::ADDR_BUS_CFG, 32'h0000_0002);
		apb(1, host_bus_pkg::ADDR_STATUS, 32'h0000_0044);
		apb(0, host_bus_pkg::ADDR_STATUS, 32'h0);
		chk("ie_halted", 32'h0000_0044, rv);
		apb(0, host_bus_pkg::ADDR_BUS_CFG, 32'h0);
		chk("rehalt_cfg", 32'h0000_0002, rv);
		conclude();
	end
endmodule : test_host_bus_and_csr_control
`default_nettype wire
